// ### include/msr_consts.svh
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH

// Register offsets on the plain register port.
`define MSR_OFF_MODE 8'h0B
`define MSR_OFF_RAM_MAP 8'h10
`define MSR_OFF_REG_MAP 8'h11
`define MSR_OFF_EE_MAP 8'h12
`define MSR_OFF_MISC_MAP 8'h13
`define MSR_OFF_DBG_STAT 8'h14

// Mode register field positions.
`define MSR_MODE_SPECIAL_MODE_N 7
`define MSR_MODE_MODE_STRAP_B 6
`define MSR_MODE_MODE_STRAP_A 5
`define MSR_MODE_ESTR 4
`define MSR_MODE_INTERNAL_VISIBILITY 3
`define MSR_MODE_EMD 1
`define MSR_MODE_EME 0

// Eeprom map and misc map field positions.
`define MSR_EE_ON 0
`define MSR_MISC_EXTRA_WINDOW_DIRECT_SELECT 0
`define MSR_MISC_EXTRA_WINDOW_ENABLE 1

// Reset locations, as upper address bits.
`define MSR_RST_REG_BASE 5'h00
`define MSR_RST_RAM_BASE 5'h01
`define MSR_RST_EE_BASE_EXP 4'h1
`define MSR_RST_EE_BASE_SINGLE 4'hF

// Debug monitor address ranges.
`define MSR_DBG_REG_LO 16'hFF00
`define MSR_DBG_REG_HI 16'hFF06
`define MSR_DBG_ROM_LO 16'hFF20

// Extra page window locations, upper six address bits.
`define MSR_EW_DIRECT 6'h00
`define MSR_EW_UPPER 6'h01

`endif

// ### include/msr_pkg.sv
package msr_pkg;

  // Operating modes after decoding the three mode bits.
  typedef enum logic [2:0] {
    MSR_SPECIAL_SINGLE,
    MSR_SPECIAL_NARROW,
    MSR_SPECIAL_PERIPH,
    MSR_SPECIAL_WIDE,
    MSR_NORMAL_SINGLE,
    MSR_NORMAL_NARROW,
    MSR_NORMAL_WIDE
  } msr_mode_t;

  // Resource that claims one bus access.
  typedef enum logic [2:0] {
    MSR_TGT_DBG_ROM,
    MSR_TGT_DBG_REGS,
    MSR_TGT_REGS,
    MSR_TGT_RAM,
    MSR_TGT_EEPROM,
    MSR_TGT_EXTERNAL
  } msr_target_t;

  // Mapping state in effect.
  typedef struct packed {
    logic [4:0] reg_base;
    logic [4:0] ram_base;
    logic [3:0] ee_base;
    logic ee_on;
    logic ew_en;
    logic ew_dir;
  } msr_map_t;

  // Pin roles of the ports.
  typedef struct packed {
    logic port_ab_addr;
    logic port_c_data;
    logic port_d_data;
    logic port_e_bus_ctl;
    logic cpu_halt;
  } msr_roles_t;

endpackage

// ### hdl/msr_mode_map.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "msr_consts.svh"

module msr_mode_map #(
  parameter logic [15:0] PROG_WIN_BASE = 16'h8000,
  parameter logic [15:0] PROG_WIN_SIZE = 16'h4000,
  parameter logic [15:0] DATA_WIN_BASE = 16'h7000,
  parameter logic [15:0] DATA_WIN_SIZE = 16'h1000
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Mode straps.
  input wire logic debug_strap_pin_i,
  input wire logic mode_strap_b_i,
  input wire logic mode_strap_a_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Debug monitor control.
  input wire logic dbg_enable_cmd_i,
  input wire logic dbg_serial_activate_i,
  input wire logic background_instruction_i,
  input wire logic dbg_exit_i,
  input wire logic vec_fetch_i,
  output logic vec_from_monitor_o,
  output logic dbg_active_o,
  // Bus access from the core.
  input wire logic acc_valid_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic acc_wide_i,
  input wire logic [15:0] acc_wdata_i,
  output msr_pkg::msr_target_t acc_target_o,
  output logic acc_done_o,
  output logic ext_busy_o,
  output logic prog_win_hit_o,
  output logic data_win_hit_o,
  output logic extra_win_hit_o,
  // External bus and pin roles.
  output logic bus_cycle_o,
  output logic [15:0] addr_bus_o,
  output logic [7:0] data_hi_o,
  output logic [7:0] data_lo_o,
  output msr_pkg::msr_roles_t roles_o
);

  function automatic msr_pkg::msr_mode_t decode_mode(input logic [2:0] c);
    case (c)
      3'b000: decode_mode = msr_pkg::MSR_SPECIAL_SINGLE;
      3'b001: decode_mode = msr_pkg::MSR_SPECIAL_NARROW;
      3'b011: decode_mode = msr_pkg::MSR_SPECIAL_WIDE;
      3'b100: decode_mode = msr_pkg::MSR_NORMAL_SINGLE;
      3'b101: decode_mode = msr_pkg::MSR_NORMAL_NARROW;
      3'b111: decode_mode = msr_pkg::MSR_NORMAL_WIDE;
      default: decode_mode = msr_pkg::MSR_SPECIAL_PERIPH;
    endcase
  endfunction

  function automatic logic is_single(input msr_pkg::msr_mode_t m);
    is_single = (m == msr_pkg::MSR_SPECIAL_SINGLE) || (m == msr_pkg::MSR_NORMAL_SINGLE);
  endfunction

  function automatic logic is_narrow(input msr_pkg::msr_mode_t m);
    is_narrow = (m == msr_pkg::MSR_SPECIAL_NARROW) || (m == msr_pkg::MSR_NORMAL_NARROW);
  endfunction

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic captured_r;
  logic special_mode_n_r, mode_strap_b_r, mode_strap_a_r;
  logic estr_r, internal_visibility_r, emd_r, eme_r;
  logic mode_touched_r;
  logic [3:0] map_written_r;
  msr_pkg::msr_map_t map_r;
  logic dbg_enabled_r, dbg_active_r;
  msr_pkg::msr_mode_t mode_cur;
  logic special, periph, single, narrow, expanded;
  msr_pkg::msr_target_t tgt;
  logic [15:0] reg_lo, ram_lo, ee_lo;
  logic [7:0] rdata_nxt;
  logic vis_show, ext_go;
  typedef enum logic {BUS_IDLE, BUS_LOW} bus_state_t;
  bus_state_t bus_r;
  logic [7:0] low_byte_r;

  // Two flops release the reset; only the second one is used.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  assign mode_cur = decode_mode({special_mode_n_r, mode_strap_b_r, mode_strap_a_r});
  assign special = !special_mode_n_r;
  assign periph = (mode_cur == msr_pkg::MSR_SPECIAL_PERIPH);
  assign single = is_single(mode_cur);
  assign narrow = is_narrow(mode_cur);
  assign expanded = !single;

  // Straps are sampled by a clocked process at the first edge after release,
  // since an asynchronous reset may only load constants.
  // strap capture once
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      captured_r <= 1'b0;
    else
      captured_r <= 1'b1;
  end

  // Mode register, including the per-bit write protection.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      special_mode_n_r <= 1'b1;
      mode_strap_b_r <= 1'b0;
      mode_strap_a_r <= 1'b0;
      estr_r <= 1'b1;
      internal_visibility_r <= 1'b0;
      emd_r <= 1'b0;
      eme_r <= 1'b0;
      mode_touched_r <= 1'b0;
    end
    else if (!captured_r)
    begin
      special_mode_n_r <= debug_strap_pin_i;
      mode_strap_b_r <= mode_strap_b_i;
      mode_strap_a_r <= mode_strap_a_i;
      estr_r <= 1'b1;
      internal_visibility_r <= !debug_strap_pin_i;
      emd_r <= !debug_strap_pin_i;
      eme_r <= !debug_strap_pin_i;
    end
    else if (reg_we_i && reg_addr_i == `MSR_OFF_MODE && !periph)
    begin
      mode_touched_r <= 1'b1;
      if (special)
      begin
        estr_r <= reg_wdata_i[`MSR_MODE_ESTR];
        // Peripheral and reserved codes cannot be selected by software.
        if (mode_touched_r && decode_mode(reg_wdata_i[7:5]) != msr_pkg::MSR_SPECIAL_PERIPH)
        begin
          special_mode_n_r <= reg_wdata_i[`MSR_MODE_SPECIAL_MODE_N];
          mode_strap_b_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_B];
          mode_strap_a_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_A];
        end
        else if (decode_mode({1'b0, reg_wdata_i[6:5]}) != msr_pkg::MSR_SPECIAL_PERIPH)
        begin
          mode_strap_b_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_B];
          mode_strap_a_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_A];
        end
        if (mode_touched_r)
        begin
          internal_visibility_r <= reg_wdata_i[`MSR_MODE_INTERNAL_VISIBILITY];
          emd_r <= reg_wdata_i[`MSR_MODE_EMD];
          eme_r <= reg_wdata_i[`MSR_MODE_EME];
        end
      end
      else if (!mode_touched_r)
      begin
        estr_r <= reg_wdata_i[`MSR_MODE_ESTR];
        internal_visibility_r <= reg_wdata_i[`MSR_MODE_INTERNAL_VISIBILITY];
        emd_r <= reg_wdata_i[`MSR_MODE_EMD];
        eme_r <= reg_wdata_i[`MSR_MODE_EME];
        if (decode_mode({1'b1, reg_wdata_i[6:5]}) != msr_pkg::MSR_SPECIAL_PERIPH)
        begin
          mode_strap_b_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_B];
          mode_strap_a_r <= reg_wdata_i[`MSR_MODE_MODE_STRAP_A];
        end
      end
    end
  end

  // Mapping registers; the stored value is the one in effect from the next cycle.
  // next cycle effect
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      map_r <= '{`MSR_RST_REG_BASE, `MSR_RST_RAM_BASE, `MSR_RST_EE_BASE_EXP,
                 1'b1, 1'b0, 1'b0};
      map_written_r <= 4'h0;
    end
    else if (!captured_r)
    begin
      if (mode_strap_b_i == 1'b0 && mode_strap_a_i == 1'b0)
        map_r.ee_base <= `MSR_RST_EE_BASE_SINGLE;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i == `MSR_OFF_REG_MAP && (special || !map_written_r[0]))
      begin
        map_r.reg_base <= reg_wdata_i[7:3];
        map_written_r[0] <= 1'b1;
      end
      else if (reg_addr_i == `MSR_OFF_RAM_MAP && (special || !map_written_r[1]))
      begin
        map_r.ram_base <= reg_wdata_i[7:3];
        map_written_r[1] <= 1'b1;
      end
      else if (reg_addr_i == `MSR_OFF_EE_MAP)
      begin
        // The enable bit is writable anytime; the position only once when normal.
        map_r.ee_on <= reg_wdata_i[`MSR_EE_ON];
        if (special || !map_written_r[2])
        begin
          map_r.ee_base <= reg_wdata_i[7:4];
          map_written_r[2] <= 1'b1;
        end
      end
      else if (reg_addr_i == `MSR_OFF_MISC_MAP && (special || !map_written_r[3]))
      begin
        map_r.ew_en <= reg_wdata_i[`MSR_MISC_EXTRA_WINDOW_ENABLE];
        map_r.ew_dir <= reg_wdata_i[`MSR_MISC_EXTRA_WINDOW_DIRECT_SELECT];
        map_written_r[3] <= 1'b1;
      end
    end
  end

  // Debug monitor enable and activity.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbg_enabled_r <= 1'b0;
      dbg_active_r <= 1'b0;
    end
    else if (!captured_r)
    begin
      dbg_enabled_r <= !debug_strap_pin_i && !mode_strap_b_i && !mode_strap_a_i;
      dbg_active_r <= !debug_strap_pin_i && !mode_strap_b_i && !mode_strap_a_i;
    end
    else
    begin
      if (dbg_enable_cmd_i)
        dbg_enabled_r <= 1'b1;
      if (dbg_enabled_r && (dbg_serial_activate_i || background_instruction_i))
        dbg_active_r <= 1'b1;
      else if (dbg_exit_i)
        dbg_active_r <= 1'b0;
    end
  end

  assign reg_lo = {map_r.reg_base, 11'h000};
  // RAM sits at the start of its 2-Kbyte block, so the reset base lands on 0800.
  assign ram_lo = {map_r.ram_base, 11'h000};
  assign ee_lo = {map_r.ee_base, 12'h000};

  // Resource decode with fixed precedence over the mapping now in effect.
  // precedence chain
  always_comb
  begin
    tgt = msr_pkg::MSR_TGT_EXTERNAL;
    if (dbg_active_r && acc_addr_i >= `MSR_DBG_ROM_LO)
      tgt = msr_pkg::MSR_TGT_DBG_ROM;
    else if (dbg_active_r && acc_addr_i >= `MSR_DBG_REG_LO)
      tgt = msr_pkg::MSR_TGT_DBG_REGS;
    else if (acc_addr_i[15:9] == reg_lo[15:9])
      tgt = msr_pkg::MSR_TGT_REGS;
    else if (acc_addr_i[15:10] == ram_lo[15:10])
      tgt = msr_pkg::MSR_TGT_RAM;
    else if ((map_r.ee_on || single) && acc_addr_i[15:12] == ee_lo[15:12])
      tgt = msr_pkg::MSR_TGT_EEPROM;
  end

  // Registered decode result and window hits.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_target_o <= msr_pkg::MSR_TGT_EXTERNAL;
      acc_done_o <= 1'b0;
      prog_win_hit_o <= 1'b0;
      data_win_hit_o <= 1'b0;
      extra_win_hit_o <= 1'b0;
    end
    else
    begin
      acc_done_o <= acc_valid_i && bus_r == BUS_IDLE;
      acc_target_o <= tgt;
      prog_win_hit_o <= expanded && acc_addr_i >= PROG_WIN_BASE &&
                        acc_addr_i - PROG_WIN_BASE < PROG_WIN_SIZE;
      data_win_hit_o <= expanded && acc_addr_i >= DATA_WIN_BASE &&
                        acc_addr_i - DATA_WIN_BASE < DATA_WIN_SIZE;
      extra_win_hit_o <= expanded && map_r.ew_en && acc_addr_i[15:10] ==
                         (map_r.ew_dir ? `MSR_EW_DIRECT : `MSR_EW_UPPER);
    end
  end

  // internal accesses shown on the external bus in any expanded mode but peripheral
  assign vis_show = expanded && internal_visibility_r && tgt != msr_pkg::MSR_TGT_EXTERNAL;
  assign ext_go = acc_valid_i && bus_r == BUS_IDLE && expanded && !periph &&
                  (tgt == msr_pkg::MSR_TGT_EXTERNAL || vis_show);

  // External bus sequencer; a narrow word takes two back-to-back cycles, except a shown internal access in special narrow with emd_r set.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_r <= BUS_IDLE;
      bus_cycle_o <= 1'b0;
      addr_bus_o <= 16'h0000;
      data_hi_o <= 8'h00;
      data_lo_o <= 8'h00;
      low_byte_r <= 8'h00;
      ext_busy_o <= 1'b0;
    end
    else
    begin
      bus_cycle_o <= 1'b0;
      ext_busy_o <= 1'b0;
      case (bus_r)
        BUS_IDLE:
        begin
          if (ext_go)
          begin
            bus_cycle_o <= 1'b1;
            addr_bus_o <= acc_addr_i;
            data_hi_o <= acc_wdata_i[15:8];
            data_lo_o <= acc_wdata_i[7:0];
            if (narrow && acc_wide_i &&
                !(mode_cur == msr_pkg::MSR_SPECIAL_NARROW && emd_r && vis_show))
            begin
              low_byte_r <= acc_wdata_i[7:0];
              bus_r <= BUS_LOW;
              ext_busy_o <= 1'b1;
            end
          end
        end
        BUS_LOW:
        begin
          bus_cycle_o <= 1'b1;
          addr_bus_o <= addr_bus_o + 16'h0001;
          data_hi_o <= low_byte_r;
          bus_r <= BUS_IDLE;
        end
        default: bus_r <= BUS_IDLE;
      endcase
    end
  end

  // Port roles and debug outputs follow the mode each cycle.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      roles_o <= '0;
      dbg_active_o <= 1'b0;
      vec_from_monitor_o <= 1'b0;
    end
    else
    begin
      // wide ports A B C D
      roles_o.port_ab_addr <= expanded;
      roles_o.port_c_data <= expanded;
      roles_o.port_d_data <= expanded && (!narrow || (mode_cur ==
                             msr_pkg::MSR_SPECIAL_NARROW && emd_r && internal_visibility_r));
      roles_o.port_e_bus_ctl <= expanded && (eme_r || mode_cur == msr_pkg::MSR_SPECIAL_WIDE);
      roles_o.cpu_halt <= periph;
      dbg_active_o <= dbg_active_r;
      vec_from_monitor_o <= vec_fetch_i && dbg_active_r;
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_addr_i == `MSR_OFF_MODE && !periph)
      rdata_nxt = {special_mode_n_r, mode_strap_b_r, mode_strap_a_r, estr_r, internal_visibility_r, 1'b0, emd_r, eme_r};
    else if (reg_addr_i == `MSR_OFF_REG_MAP)
      rdata_nxt = {map_r.reg_base, 3'b000};
    else if (reg_addr_i == `MSR_OFF_RAM_MAP)
      rdata_nxt = {map_r.ram_base, 3'b000};
    else if (reg_addr_i == `MSR_OFF_EE_MAP)
      rdata_nxt = {map_r.ee_base, 3'b000, map_r.ee_on || single};
    else if (reg_addr_i == `MSR_OFF_MISC_MAP)
      rdata_nxt = {6'h00, map_r.ew_en, map_r.ew_dir};
    else if (reg_addr_i == `MSR_OFF_DBG_STAT)
      rdata_nxt = {6'h00, dbg_active_r, dbg_enabled_r};
  end

  // Read data stand for the one cycle after the strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_re_i ? rdata_nxt : 8'h00;
  end

  property p_strap_capture;
    @(posedge ref_clk_i) disable iff (!rst_n)
    $rose(captured_r) |-> {special_mode_n_r, mode_strap_b_r, mode_strap_a_r} ==
      $past({debug_strap_pin_i, mode_strap_b_i, mode_strap_a_i});
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("mode bits miss straps");

  property p_reserved_forced;
    @(posedge ref_clk_i) disable iff (!rst_n)
    $rose(captured_r) && $past({debug_strap_pin_i, mode_strap_b_i, mode_strap_a_i}) == 3'b110
      |-> mode_cur == msr_pkg::MSR_SPECIAL_PERIPH ##1 roles_o.cpu_halt;
  endproperty
  a_reserved_forced: assert property (p_reserved_forced) else $error("reserved not periph");

  property p_wide_word;
    @(posedge ref_clk_i) disable iff (!rst_n)
    ext_go && !narrow |=> bus_cycle_o && data_hi_o == $past(acc_wdata_i[15:8]) &&
      data_lo_o == $past(acc_wdata_i[7:0]) ##1 !bus_cycle_o || $past(ext_go);
  endproperty
  a_wide_word: assert property (p_wide_word) else $error("wide word not on C and D");

  property p_narrow_split;
    @(posedge ref_clk_i) disable iff (!rst_n)
    ext_go && narrow && acc_wide_i && !emd_r |=> bus_cycle_o && ext_busy_o
      ##1 bus_cycle_o && addr_bus_o == $past(addr_bus_o) + 16'h0001 &&
      data_hi_o == $past(data_lo_o);
  endproperty
  a_narrow_split: assert property (p_narrow_split) else $error("narrow split wrong");

  property p_single_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n)
    single && $past(single) && $past(single, 2) |-> !bus_cycle_o;
  endproperty
  a_single_quiet: assert property (p_single_quiet) else $error("bus cycle in single-chip");

  property p_periph_locked;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_r && periph |=> periph [*2];
  endproperty
  a_periph_locked: assert property (p_periph_locked) else $error("left peripheral mode");

  property p_write_once;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_r && !special && map_written_r[0] && reg_we_i &&
      reg_addr_i == `MSR_OFF_REG_MAP |=> $stable(map_r.reg_base);
  endproperty
  a_write_once: assert property (p_write_once) else $error("map rewritten in normal mode");

  property p_map_effect;
    @(posedge ref_clk_i) disable iff (!rst_n)
    captured_r && special && reg_we_i && reg_addr_i == `MSR_OFF_RAM_MAP
      |=> map_r.ram_base == $past(reg_wdata_i[7:3]);
  endproperty
  a_map_effect: assert property (p_map_effect) else $error("mapping not applied");

  property p_monitor_rom;
    @(posedge ref_clk_i) disable iff (!rst_n)
    dbg_active_r && acc_valid_i && acc_addr_i >= `MSR_DBG_ROM_LO
      |=> acc_target_o == msr_pkg::MSR_TGT_DBG_ROM;
  endproperty
  a_monitor_rom: assert property (p_monitor_rom) else $error("monitor ROM not selected");

  property p_special_single_dbg;
    @(posedge ref_clk_i) disable iff (!rst_n)
    $rose(captured_r) |-> dbg_active_r == (mode_cur == msr_pkg::MSR_SPECIAL_SINGLE);
  endproperty
  a_special_single_dbg: assert property (p_special_single_dbg) else $error("monitor reset state");

endmodule

// ### tb/msr_ext_mem.sv
`timescale 1ns/1ps
// Passive external memory; it only records what the block puts on its buses.
module msr_ext_mem (
  // Bus from the block.
  input wire logic clk_i,
  input wire logic bus_cycle_i,
  input wire logic wide_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // Lookup for the bench.
  input wire logic [15:0] peek_i,
  output logic [7:0] peek_o
);
  logic [7:0] mem [0:65535];
  // Port C holds the byte at the cycle address, port D the next one when wide.
  // lane placement
  always @(posedge clk_i)
  begin
    if (bus_cycle_i)
    begin
      mem[addr_i] = hi_i;
      if (wide_i)
        mem[addr_i + 16'h0001] = lo_i;
    end
  end
  // Unwritten places stay unknown, so a missing cycle can never pass a check.
  assign peek_o = mem[peek_i];
endmodule

// ### tb/mode_select_resource_map_bench.sv
`timescale 1ns/1ps
`include "msr_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mode_select_resource_map_bench;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, vf = 1'b0, av = 1'b0, aw = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [3:0] dbg = 4'h0;
  logic [7:0] ra = 8'h00, rw = 8'h00, rdata, dhi, dlo, peek_d;
  logic [15:0] aa = 16'h0000, ad = 16'h0000, ab;
  logic vfm, dact, busy, ewh, bc;
  msr_pkg::msr_target_t tgt;
  msr_pkg::msr_roles_t roles;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // Each row packs roles (13:9), monitor active (8) and mode register value (7:0).
  logic [13:0] rows [8] = '{14'h011B, 14'h3C3B, 14'h3E00, 14'h3C7B,
    14'h0090, 14'h30B0, 14'h3E00, 14'h38F0};

  msr_mode_map u_msr_mode_map (.ref_clk_i(clk), .rst_n_i(rst_n),
    .debug_strap_pin_i(strap[2]), .mode_strap_b_i(strap[1]), .mode_strap_a_i(strap[0]),
    .reg_addr_i(ra), .reg_wdata_i(rw), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .dbg_enable_cmd_i(dbg[3]), .dbg_serial_activate_i(dbg[2]),
    .background_instruction_i(dbg[1]), .dbg_exit_i(dbg[0]), .vec_fetch_i(vf),
    .vec_from_monitor_o(vfm), .dbg_active_o(dact), .acc_valid_i(av), .acc_addr_i(aa),
    .acc_wide_i(aw), .acc_wdata_i(ad), .acc_target_o(tgt), .acc_done_o(), .ext_busy_o(busy),
    .prog_win_hit_o(), .data_win_hit_o(), .extra_win_hit_o(ewh), .bus_cycle_o(bc),
    .addr_bus_o(ab), .data_hi_o(dhi), .data_lo_o(dlo), .roles_o(roles));

  msr_ext_mem u_msr_ext_mem (.clk_i(clk), .bus_cycle_i(bc), .wide_i(roles.port_d_data),
    .addr_i(ab), .hi_i(dhi), .lo_i(dlo), .peek_i(16'h4001), .peek_o(peek_d));

  // A 5 ns clock.
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // A run of a few hundred cycles; the ceiling only catches a hang.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Straps stay steady over the whole reset and the capture edges after it.
  task automatic reset_to(input logic [2:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= c;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rw <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  // The gap before each access also keeps a mapping write clear of decoding.
  // idle cycle after write
  task automatic acc(input logic [15:0] a, input logic [15:0] d = 16'h0000,
    input logic w = 1'b0);
    @(posedge clk);
    aa <= a;
    ad <= d;
    aw <= w;
    av <= 1'b1;
    @(posedge clk);
    av <= 1'b0;
    #1;
  endtask

  // Bits are enable, serial activate, background instruction, exit.
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    dbg <= v;
    @(posedge clk);
    dbg <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial
  begin
    // Every strap code; peripheral codes leave the port E role open.
    // no monitor use in peripheral mode
    for (int i = 0; i < 8; i++)
    begin
      reset_to(i[2:0]);
      `CHK(roles | ((i % 4 == 2) ? 5'b00010 : 5'b00000), rows[i][13:9])
      `CHK(dact, rows[i][8])
      rd(`MSR_OFF_MODE, rows[i][7:0]);
      $display("strap code %0d done", i);
    end
    // Normal wide: reset map, remapping, write-once mapping, wide bus.
    acc(16'h0900);
    `CHK(tgt, msr_pkg::MSR_TGT_RAM)
    wr(`MSR_OFF_RAM_MAP, 8'h00);
    wr(`MSR_OFF_REG_MAP, 8'h20);
    acc(16'h0300);
    `CHK(tgt, msr_pkg::MSR_TGT_RAM)
    acc(16'h2100);
    `CHK(tgt, msr_pkg::MSR_TGT_REGS)
    wr(`MSR_OFF_REG_MAP, 8'h00);
    acc(16'h0100);
    `CHK(tgt, msr_pkg::MSR_TGT_RAM)
    wr(`MSR_OFF_RAM_MAP, 8'h40);
    rd(`MSR_OFF_RAM_MAP, 8'h00);
    acc(16'h4000, 16'h1234, 1'b1);
    `CHK(tgt, msr_pkg::MSR_TGT_EXTERNAL)
    `CHK({bc, ab, dhi, dlo}, {1'b1, 16'h4000, 16'h1234})
    $display("normal wide done");
    // Special narrow: split word, rewrites, extra window, debug monitor.
    reset_to(3'b001);
    acc(16'h4000, 16'hABCD, 1'b1);
    `CHK({bc, busy, ab, dhi}, {2'b11, 16'h4000, 8'hAB})
    @(posedge clk);
    #1 `CHK({bc, ab, dhi}, {1'b1, 16'h4001, 8'hCD})
    wr(`MSR_OFF_RAM_MAP, 8'h00);
    wr(`MSR_OFF_RAM_MAP, 8'h40);
    rd(`MSR_OFF_RAM_MAP, 8'h40);
    `CHK(peek_d, 8'hCD)
    wr(`MSR_OFF_MISC_MAP, 8'h03);
    acc(16'h0250);
    `CHK(ewh, 1'b1)
    pulse(4'b0010);
    `CHK(dact, 1'b0)
    pulse(4'b1000);
    pulse(4'b0100);
    `CHK(dact, 1'b1)
    acc(16'hFF30);
    `CHK(tgt, msr_pkg::MSR_TGT_DBG_ROM)
    acc(16'hFF03);
    `CHK(tgt, msr_pkg::MSR_TGT_DBG_REGS)
    @(posedge clk);
    vf <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK(vfm, 1'b1)
    pulse(4'b0001);
    pulse(4'b0010);
    `CHK(dact, 1'b1)
    $display("special narrow done");
    print_verdict();
  end
endmodule
